/* rtl/als_pkg.sv */
// ************************************************************
// shared constants and carriers
// ************************************************************
package als_pkg;
	// bus address bytes, write and read
	localparam logic [7:0] BUS_WR_ADDR = 8'h26;
	localparam logic [7:0] BUS_RD_ADDR = 8'h27;
	// register offsets
	localparam logic [7:0] REG_CTRL = 8'h80;
	localparam logic [7:0] REG_LED = 8'h83;
	localparam logic [7:0] REG_PARAM = 8'h84;
	localparam logic [7:0] REG_RES_HI = 8'h85;
	localparam logic [7:0] REG_RES_LO = 8'h86;
	localparam logic [7:0] REG_STATUS = 8'h8e;
	// field positions
	localparam int CTRL_ALS_EN_BIT = 0;
	localparam int CTRL_PROX_EN_BIT = 1;
	localparam int PARAM_CONT_BIT = 7;
	localparam int PARAM_AVG_LSB = 0;
	localparam int AVG_W = 3;
	localparam int STATUS_ALS_BIT = 2;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] LED_RST = 8'h00;
	localparam logic [7:0] PARAM_RST = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	// timing
	localparam int CORE_CLK_NS = 40;
	localparam int CONV_TIME_NS = 300000;
	localparam int FRAME_TIME_MS = 100;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
	localparam int FRAME_CYCLES = FRAME_TIME_MS * 1000000 / CORE_CLK_NS;
	// one register write from the bus
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} wr_evt_t;
	// readable register image sent toward the bus side
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] led;
		logic [7:0] param;
		logic [7:0] status;
		logic [15:0] result;
	} readback_t;
endpackage : als_pkg

/* rtl/cdc_word_xfer.sv */
`timescale 1ns/100ps
// ************************************************************
// two-phase toggle handshake carrying one word
// ************************************************************
module cdc_word_xfer #(
	parameter int W = 8
) (
	// clocks and reset
	input wire logic src_clk_in,
	input wire logic dst_clk_in,
	input wire logic rst_in,
	// source side
	input wire logic send_in,
	input wire logic [W-1:0] data_in,
	output logic busy_out,
	// destination side
	output logic [W-1:0] dst_data_out,
	output logic dst_pulse_out
);
	logic req_q, req_d; // source toggle
	logic [W-1:0] data_q, data_d; // held stable while busy
	logic ack_s1_q, ack_s2_q; // ack synchroniser
	logic req_s1_q, req_s2_q, req_s3_q; // req synchroniser plus edge stage
	logic [W-1:0] dst_q; // captured word
	logic pulse_q; // one destination cycle per word

	assign busy_out = req_q ^ ack_s2_q;
	assign dst_data_out = dst_q;
	assign dst_pulse_out = pulse_q;

	// new word only when the last one was acknowledged
	always_comb begin
		req_d = req_q;
		data_d = data_q;
		if (send_in && !busy_out) begin
			req_d = ~req_q;
			data_d = data_in;
		end
	end

	// source registers
	always_ff @(posedge src_clk_in or posedge rst_in) begin
		if (rst_in) begin
			req_q <= 1'b0;
			data_q <= '0;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			req_q <= req_d;
			data_q <= data_d;
			ack_s1_q <= req_s2_q;
			ack_s2_q <= ack_s1_q;
		end
	end

	// destination registers; data is safe since it holds until ack returns
	always_ff @(posedge dst_clk_in or posedge rst_in) begin
		if (rst_in) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
			dst_q <= '0;
			pulse_q <= 1'b0;
		end else begin
			req_s1_q <= req_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			pulse_q <= req_s2_q ^ req_s3_q;
			if (req_s2_q ^ req_s3_q) begin
				dst_q <= data_q;
			end
		end
	end
endmodule : cdc_word_xfer

/* rtl/i2c_target_engine.sv */
`timescale 1ns/100ps
// ************************************************************
// two-wire target, clocked by the bus clock
// ************************************************************
module i2c_target_engine (
	// link
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic rst_in,
	output logic sda_oe_out,
	// register image and write path
	input wire als_pkg::readback_t snap_in,
	input wire logic wr_busy_in,
	output logic wr_send_out,
	output als_pkg::wr_evt_t wr_evt_out
);
	typedef enum logic [2:0] {ADDR, PTR, WDATA, RDATA, IGNORE} tstate_t;
	tstate_t st_q, st_d; // transfer phase
	logic [3:0] cnt_q, cnt_d; // bits of current byte, 8 = ack slot
	logic [7:0] sh_q, sh_d; // receive shifter
	logic [7:0] tx_q, tx_d; // byte being sent
	logic [7:0] ptr_q, ptr_d; // register pointer
	logic ack_q, ack_d; // acknowledge the byte just taken
	logic seen_q, seen_d; // last start toggle seen
	logic start_tog_q; // flips on every start
	als_pkg::readback_t snap_q, snap_d; // frozen during reads
	logic [7:0] rd_byte; // register at pointer
	logic oe_d; // drive low next half

	// start marker; sda as clock so a start is caught with scl high
	always_ff @(negedge sda_in or posedge rst_in) begin
		if (rst_in) start_tog_q <= 1'b0;
		else if (scl_in) start_tog_q <= ~start_tog_q;
	end

	// register image lookup
	always_comb begin
		rd_byte = 8'h00;
		if (ptr_q == als_pkg::REG_CTRL) rd_byte = snap_q.ctrl;
		else if (ptr_q == als_pkg::REG_LED) rd_byte = snap_q.led;
		else if (ptr_q == als_pkg::REG_PARAM) rd_byte = snap_q.param;
		else if (ptr_q == als_pkg::REG_RES_HI) rd_byte = snap_q.result[15:8];
		else if (ptr_q == als_pkg::REG_RES_LO) rd_byte = snap_q.result[7:0];
		else if (ptr_q == als_pkg::REG_STATUS) rd_byte = snap_q.status;
	end

	// byte and phase sequencing on rising scl
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		ack_d = ack_q;
		wr_send_out = 1'b0;
		wr_evt_out = '{addr: ptr_q, data: sh_q};
		seen_d = start_tog_q;
		// snapshot held while a read is in flight, so high and low pair up
		snap_d = (st_q == RDATA) ? snap_q : snap_in;
		if (start_tog_q != seen_q) begin
			// start or repeated start both reopen addressing
			st_d = ADDR;
			cnt_d = 4'd1;
			sh_d = {7'h00, sda_in};
			ack_d = 1'b0;
		end else if (cnt_q < 4'd8) begin
			sh_d = {sh_q[6:0], sda_in};
			cnt_d = cnt_q + 4'd1;
			if (cnt_q == 4'd7) begin
				case (st_q)
					ADDR: ack_d = (sh_d == als_pkg::BUS_WR_ADDR) ||
						(sh_d == als_pkg::BUS_RD_ADDR);
					PTR, WDATA: ack_d = 1'b1;
					default: ack_d = 1'b0;
				endcase
			end
		end else begin
			cnt_d = 4'd0;
			ack_d = 1'b0;
			case (st_q)
				ADDR: begin
					if (!ack_q) st_d = IGNORE;
					else if (sh_q[0]) begin
						st_d = RDATA;
						tx_d = rd_byte;
						ptr_d = ptr_q + 8'd1;
					end else st_d = PTR;
				end
				PTR: begin
					ptr_d = sh_q;
					st_d = WDATA;
				end
				WDATA: begin
					// a write still crossing makes this one drop, as the handshake cannot queue
					wr_send_out = !wr_busy_in;
					ptr_d = ptr_q + 8'd1;
				end
				RDATA: begin
					if (sda_in) st_d = IGNORE; // host nack ends the read
					else begin
						tx_d = rd_byte;
						ptr_d = ptr_q + 8'd1;
					end
				end
				default: st_d = IGNORE;
			endcase
		end
	end

	// drive low for ack or for a zero data bit
	always_comb begin
		oe_d = 1'b0;
		if (cnt_q == 4'd8) oe_d = ack_q;
		else if (st_q == RDATA) oe_d = ~tx_q[3'(4'd7 - cnt_q)];
	end

	// rising-edge registers
	always_ff @(posedge scl_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= IGNORE;
			cnt_q <= 4'd0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			ack_q <= 1'b0;
			seen_q <= 1'b0;
			snap_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			ack_q <= ack_d;
			seen_q <= seen_d;
			snap_q <= snap_d;
		end
	end

	// output changes only while scl is low
	always_ff @(negedge scl_in or posedge rst_in) begin
		if (rst_in) sda_oe_out <= 1'b0;
		else sda_oe_out <= oe_d;
	end

	// ************************************************************
	// checks
	// ************************************************************
	ptr_incr_a: assert property (@(posedge scl_in) disable iff (rst_in)
		(st_q == RDATA && cnt_q == 4'd8 && !sda_in && start_tog_q == seen_q)
		|=> ptr_q == $past(ptr_q) + 8'd1)
		else $error("pointer did not advance after a read byte");
	addr_ack_a: assert property (@(posedge scl_in) disable iff (rst_in)
		(st_q == ADDR && cnt_q == 4'd8 && ack_q)
		|-> (sh_q == als_pkg::BUS_WR_ADDR || sh_q == als_pkg::BUS_RD_ADDR))
		else $error("acknowledged a foreign address");
	read_cov_c: cover property (@(posedge scl_in) disable iff (rst_in)
		st_q == RDATA && cnt_q == 4'd8 && !sda_in);
endmodule : i2c_target_engine

/* rtl/als_sensor_top.sv */
`timescale 1ns/100ps
// Summary of operation
// - standby with only bus logic when idle
// - emitter sink off in standby
// - read returns register at current pointer
// - stop-start or repeated start both accepted
// - pointer increments after each read byte
// - answer write 26h and read 27h
// - result high at 85h, low at 86h
// - standard mode uses fixed 100 ms frame
// - each conversion lasts about 300 us
// - averaging up to 128 conversions
// - result is mean of the conversions
// - standard mode publishes only at frame end
// - continuous mode runs conversions back to back
// - status sticky, write one clears, int low
module als_sensor_top #(
	parameter int CONV_CYC = als_pkg::CONV_CYCLES,
	parameter int FRAME_CYC = als_pkg::FRAME_CYCLES
) (
	// core clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// two-wire link
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// light front end
	input wire logic [15:0] als_sample_in,
	output logic conv_active_out,
	// power and emitter
	output logic ir_sink_en_out,
	output logic standby_out,
	// interrupt pad
	output logic int_n_out
);
	localparam int CW = $clog2(CONV_CYC + 1);
	localparam int FW = $clog2(FRAME_CYC + 1);
	localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);
	localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYC - 1);

	// ************************************************************
	// declarations
	// ************************************************************
	typedef enum logic [1:0] {IDLE, CONV, HOLD} sched_t;
	sched_t st_q, st_d; // conversion scheduler
	logic [7:0] ctrl_q, ctrl_d; // measurement enables
	logic [7:0] led_q, led_d; // emitter current setting, stored only
	logic [7:0] param_q, param_d; // mode and averaging
	logic [7:0] status_q, status_d; // sticky events
	logic [15:0] result_q, result_d; // averaged light level
	logic [CW-1:0] conv_cnt_q, conv_cnt_d; // time within one conversion
	logic [FW-1:0] frame_cnt_q, frame_cnt_d; // time within standard frame
	logic [7:0] n_q, n_d; // conversions taken this result
	logic [22:0] acc_q, acc_d; // sum of up to 128 samples
	logic standby_q, standby_d;
	logic ir_sink_q, ir_sink_d;
	logic conv_act_q, conv_act_d;
	logic int_n_q, int_n_d;
	logic sda_q; // open-drain level, always low
	als_pkg::readback_t rb_now, rb_sent_q, rb_sent_d; // image toward link
	als_pkg::readback_t rb_link; // image in link domain
	als_pkg::wr_evt_t wr_link, wr_core; // register writes
	logic wr_link_send, wr_link_busy, wr_pulse, rb_busy, rb_send;
	logic publish; // new result this cycle
	logic [15:0] pub_val; // value being published
	localparam int AVG_W_L = als_pkg::AVG_W; // width of the averaging field
	logic [AVG_W_L-1:0] avg_exp; // log2 of averaging count
	logic [7:0] n_last; // index of final conversion
	logic [22:0] sum_w; // running sum with current sample
	logic cont; // continuous mode

	assign sda_out = sda_q;
	assign standby_out = standby_q;
	assign ir_sink_en_out = ir_sink_q;
	assign conv_active_out = conv_act_q;
	assign int_n_out = int_n_q;

	// ************************************************************
	// link side and crossings
	// ************************************************************
	i2c_target_engine u_engine (
		.scl_in(scl_in),
		.sda_in(sda_in),
		.rst_in(rst_in),
		.sda_oe_out(sda_oe_out),
		.snap_in(rb_link),
		.wr_busy_in(wr_link_busy),
		.wr_send_out(wr_link_send),
		.wr_evt_out(wr_link)
	);

	// writes cross from the link clock into the core
	cdc_word_xfer #(.W($bits(als_pkg::wr_evt_t))) u_wr_xfer (
		.src_clk_in(scl_in),
		.dst_clk_in(core_clk_in),
		.rst_in(rst_in),
		.send_in(wr_link_send),
		.data_in(wr_link),
		.busy_out(wr_link_busy),
		.dst_data_out(wr_core),
		.dst_pulse_out(wr_pulse)
	);

	// register image crosses toward the link; waits while scl is idle
	cdc_word_xfer #(.W($bits(als_pkg::readback_t))) u_rb_xfer (
		.src_clk_in(core_clk_in),
		.dst_clk_in(scl_in),
		.rst_in(rst_in),
		.send_in(rb_send),
		.data_in(rb_now),
		.busy_out(rb_busy),
		.dst_data_out(rb_link),
		.dst_pulse_out()
	);

	// resend whenever the image differs from the last one sent
	always_comb begin
		rb_now = '{ctrl: ctrl_q, led: led_q, param: param_q, status: status_q,
			result: result_q};
		rb_send = !rb_busy && (rb_now != rb_sent_q);
		rb_sent_d = rb_send ? rb_now : rb_sent_q;
	end

	// ************************************************************
	// registers and conversion scheduler
	// ************************************************************
	always_comb begin
		cont = param_q[als_pkg::PARAM_CONT_BIT];
		avg_exp = param_q[als_pkg::PARAM_AVG_LSB +: AVG_W_L];
		n_last = 8'((9'd1 << avg_exp) - 9'd1);
		sum_w = acc_q + {7'h00, als_sample_in};
		ctrl_d = ctrl_q;
		led_d = led_q;
		param_d = param_q;
		status_d = status_q;
		result_d = result_q;
		st_d = st_q;
		conv_cnt_d = conv_cnt_q;
		frame_cnt_d = frame_cnt_q;
		n_d = n_q;
		acc_d = acc_q;
		publish = 1'b0;
		pub_val = result_q;
		// register writes from the bus
		if (wr_pulse) begin
			if (wr_core.addr == als_pkg::REG_CTRL) ctrl_d = wr_core.data;
			else if (wr_core.addr == als_pkg::REG_LED) led_d = wr_core.data;
			else if (wr_core.addr == als_pkg::REG_PARAM) param_d = wr_core.data;
			else if (wr_core.addr == als_pkg::REG_STATUS) begin
				status_d = status_q & ~wr_core.data;
			end
		end
		// frame timer runs only in standard mode
		if (st_q != IDLE && !cont) begin
			frame_cnt_d = (frame_cnt_q == FRAME_LAST) ? '0 : frame_cnt_q + 1'b1;
		end
		case (st_q)
			IDLE: begin
				if (ctrl_q[als_pkg::CTRL_ALS_EN_BIT]) begin
					st_d = CONV;
					conv_cnt_d = '0;
					frame_cnt_d = '0;
					n_d = 8'h00;
					acc_d = '0;
				end
			end
			CONV: begin
				conv_cnt_d = conv_cnt_q + 1'b1;
				if (conv_cnt_q == CONV_LAST) begin
					conv_cnt_d = '0;
					acc_d = sum_w;
					if (n_q != n_last) n_d = n_q + 8'd1;
					else if (cont) begin
						// back to back, result as soon as the set is done
						publish = 1'b1;
						pub_val = 16'(sum_w >> avg_exp);
						acc_d = '0;
						n_d = 8'h00;
					end else st_d = HOLD;
				end
			end
			HOLD: begin
				// standard result waits for the frame end whatever the count; continuous mode publishes at once
				if (cont || frame_cnt_q == FRAME_LAST) begin
					publish = 1'b1;
					pub_val = 16'(acc_q >> avg_exp);
					st_d = CONV;
					conv_cnt_d = '0;
					frame_cnt_d = '0;
					acc_d = '0;
					n_d = 8'h00;
				end
			end
			default: st_d = IDLE;
		endcase
		// disable drops straight to IDLE, any partial sum is lost
		if (!ctrl_q[als_pkg::CTRL_ALS_EN_BIT]) st_d = IDLE;
		if (publish) begin
			result_d = pub_val;
			status_d[als_pkg::STATUS_ALS_BIT] = 1'b1; // set wins over clear
		end
		standby_d = (st_d == IDLE) && !ctrl_d[als_pkg::CTRL_PROX_EN_BIT];
		ir_sink_d = !standby_d && ctrl_d[als_pkg::CTRL_PROX_EN_BIT];
		conv_act_d = (st_d == CONV);
		int_n_d = ~|status_d;
	end

	// core registers
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_q <= als_pkg::CTRL_RST;
			led_q <= als_pkg::LED_RST;
			param_q <= als_pkg::PARAM_RST;
			status_q <= als_pkg::STATUS_RST;
			result_q <= als_pkg::RESULT_RST;
			st_q <= IDLE;
			conv_cnt_q <= '0;
			frame_cnt_q <= '0;
			n_q <= 8'h00;
			acc_q <= '0;
			standby_q <= 1'b1;
			ir_sink_q <= 1'b0;
			conv_act_q <= 1'b0;
			int_n_q <= 1'b1;
			sda_q <= 1'b0;
			rb_sent_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			led_q <= led_d;
			param_q <= param_d;
			status_q <= status_d;
			result_q <= result_d;
			st_q <= st_d;
			conv_cnt_q <= conv_cnt_d;
			frame_cnt_q <= frame_cnt_d;
			n_q <= n_d;
			acc_q <= acc_d;
			standby_q <= standby_d;
			ir_sink_q <= ir_sink_d;
			conv_act_q <= conv_act_d;
			int_n_q <= int_n_d;
			sda_q <= 1'b0;
			rb_sent_q <= rb_sent_d;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	standby_idle_a: assert property (standby_q |-> st_q == IDLE)
		else $error("standby while measuring");
	sink_off_a: assert property (standby_q |-> !ir_sink_q)
		else $error("emitter sink on in standby");
	frame_end_a: assert property (publish && !cont |-> frame_cnt_q == FRAME_LAST)
		else $error("standard result outside frame end");
	conv_len_a: assert property (st_q == CONV && conv_cnt_q == CONV_LAST &&
		st_d == CONV |=> conv_cnt_q == '0)
		else $error("conversion length wrong");
	avg_count_a: assert property (publish && cont |-> n_q == n_last)
		else $error("average over wrong count");
	mean_val_a: assert property (publish && !cont && st_d == CONV
		|=> result_q == 16'($past(acc_q) >> $past(avg_exp)))
		else $error("result is not the mean");
	hold_wait_a: assert property (st_q == HOLD && frame_cnt_q != FRAME_LAST
		&& !cont |-> !publish)
		else $error("early standard result");
	cont_no_hold_a: assert property (st_q == CONV && cont |=> st_q != HOLD)
		else $error("continuous mode waited for frame");
	cont_pub_a: assert property (st_q == CONV && cont && ctrl_q[0] &&
		conv_cnt_q == CONV_LAST && n_q == n_last |-> publish)
		else $error("continuous result not published");
	sticky_int_a: assert property (publish |=>
		status_q[als_pkg::STATUS_ALS_BIT] ##1 !int_n_q)
		else $error("ready flag or interrupt missing");
	pub_cont_c: cover property (publish && cont);
	pub_std_c: cover property (publish && !cont);
	clear_c: cover property (wr_pulse && wr_core.addr == als_pkg::REG_STATUS);
endmodule : als_sensor_top

/* tb/i2c_host_model.sv */
`timescale 1ns/100ps
// ************************************************************
// two-wire host, scl stands still between frames
// ************************************************************
module i2c_host_model (
	// resolved wire
	input wire logic sda_in,
	// host drive
	output logic scl_out,
	output logic sda_oe_out
);
	// idle: scl high, sda released
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	// start or repeated start: sda falls while scl high
	task automatic start();
		if (scl_out === 1'b0) begin
			#10 sda_oe_out = 1'b0;
			#70 scl_out = 1'b1;
		end
		#80 sda_oe_out = 1'b1;
		#80 scl_out = 1'b0;
	endtask : start
	// stop: sda rises while scl high
	task automatic stop();
		#10 sda_oe_out = 1'b1;
		#70 scl_out = 1'b1;
		#80 sda_oe_out = 1'b0;
		#80;
	endtask : stop
	// one bit; sda moves 10 ns after scl falls so no false start is seen
	task automatic bit_xfer(input logic b, output logic s);
		#10 sda_oe_out = ~b;
		#70 scl_out = 1'b1;
		#70 s = sda_in;
		#10 scl_out = 1'b0;
	endtask : bit_xfer
	// byte out, msb first, returns the ack level
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(b[i], s);
		end
		bit_xfer(1'b1, ack);
	endtask : wr_byte
	// byte in; last byte gets a nack
	task automatic rd_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, s);
			b[i] = s;
		end
		bit_xfer(last, s);
	endtask : rd_byte
endmodule : i2c_host_model

/* tb/light_sensor_read_and_conversion_bench.sv */
`timescale 1ns/100ps
// ************************************************************
// bench: register reads and light conversion timing
// ************************************************************
module light_sensor_read_and_conversion_bench;
	localparam int CONV_CYC = 20; // shortened conversion
	localparam int FRAME_CYC = 6000; // shortened frame, above 128 conversions
	localparam logic [15:0] SAMPLE = 16'hff81; // near full scale, exposes unshifted sums
	logic core_clk_in;
	logic rst_in;
	logic scl;
	logic host_oe;
	logic sda;
	logic sda_out;
	logic sda_oe_out;
	logic [15:0] als_sample_in;
	logic conv_active_out;
	logic ir_sink_en_out;
	logic standby_out;
	logic int_n_out;
	int fail_count;
	int total_checks;
	// pull-up: wire low while either party pulls
	assign sda = (sda_oe_out ? sda_out : 1'b1) & ~host_oe;
	als_sensor_top #(.CONV_CYC(CONV_CYC), .FRAME_CYC(FRAME_CYC)) dut (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_out),
		.sda_oe_out(sda_oe_out),
		.als_sample_in(als_sample_in),
		.conv_active_out(conv_active_out),
		.ir_sink_en_out(ir_sink_en_out),
		.standby_out(standby_out),
		.int_n_out(int_n_out)
	);
	i2c_host_model host (.sda_in(sda), .scl_out(scl), .sda_oe_out(host_oe));
	// 25 MHz core clock
	initial begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end
	// compare one value
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// compare a cycle count against a window
	task automatic chk_span(input int got, input int lo, input int hi);
		total_checks++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("mismatch at %0t: span %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_span
	// register write: address, pointer, one data byte
	task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d);
		logic ack;
		host.start();
		host.wr_byte(als_pkg::BUS_WR_ADDR, ack);
		chk(16'(ack), 16'h0000);
		host.wr_byte(ptr, ack);
		host.wr_byte(d, ack);
		host.stop();
	endtask : reg_wr
	// two-byte read after a data-less pointer write
	task automatic reg_rd2(input logic [7:0] ptr, input logic rep, output logic [15:0] v);
		logic ack;
		logic [7:0] hi;
		logic [7:0] lo;
		host.start();
		host.wr_byte(als_pkg::BUS_WR_ADDR, ack);
		host.wr_byte(ptr, ack);
		if (!rep) begin
			host.stop();
		end
		host.start();
		host.wr_byte(als_pkg::BUS_RD_ADDR, ack);
		chk(16'(ack), 16'h0000);
		host.rd_byte(1'b0, hi);
		host.rd_byte(1'b1, lo);
		host.stop();
		v = {hi, lo};
	endtask : reg_rd2
	// bounded wait for the standby level
	task automatic wait_ctl(input logic lvl);
		for (int i = 0; i < 500 && standby_out !== lvl; i++) begin
			@(negedge core_clk_in);
		end
		chk(16'(standby_out), 16'(lvl));
	endtask : wait_ctl
	// cycles from conversion start to interrupt low
	task automatic measure(output int n);
		n = 0;
		for (int i = 0; i < 20000 && conv_active_out !== 1'b1; i++) begin
			@(negedge core_clk_in);
		end
		while (int_n_out !== 1'b0 && n < 20000) begin
			@(negedge core_clk_in);
			n++;
		end
	endtask : measure
	// read result, stop, clear the ready flag
	task automatic finish_run(input logic rep);
		logic [15:0] v;
		reg_rd2(als_pkg::REG_RES_HI, rep, v);
		chk(v, SAMPLE);
		chk(16'(int_n_out), 16'h0000);
		reg_wr(als_pkg::REG_CTRL, 8'h00);
		wait_ctl(1'b1);
		reg_wr(als_pkg::REG_STATUS, 8'h04);
		for (int i = 0; i < 500 && int_n_out !== 1'b1; i++) begin
			@(negedge core_clk_in);
		end
		chk(16'(int_n_out), 16'h0001);
	endtask : finish_run
	// verdict, the single end of the run
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	// watchdog, about four times the expected run
	initial begin
		#2000000;
		fail_count++;
		conclude();
	end
	// main sequence
	initial begin
		logic [15:0] v;
		logic ack;
		int n;
		logic [2:0] codes [3];
		codes = '{3'h0, 3'h3, 3'h7};
		fail_count = 0;
		total_checks = 0;
		rst_in = 1'b1;
		als_sample_in = SAMPLE;
		repeat (8) @(negedge core_clk_in);
		rst_in = 1'b0;
		repeat (4) @(negedge core_clk_in);
		chk(16'(standby_out), 16'h0001);
		chk(16'(ir_sink_en_out), 16'h0000);
		chk(16'(int_n_out), 16'h0001);
		reg_rd2(als_pkg::REG_RES_HI, 1'b1, v);
		chk(v, als_pkg::RESULT_RST);
		reg_rd2(8'h81, 1'b0, v);
		chk(v, 16'h0000);
		$display("test reset and readback done");
		// emitter follows the measurement request
		reg_wr(als_pkg::REG_CTRL, 8'h02);
		wait_ctl(1'b0);
		chk(16'(ir_sink_en_out), 16'h0001);
		reg_wr(als_pkg::REG_CTRL, 8'h00);
		wait_ctl(1'b1);
		chk(16'(ir_sink_en_out), 16'h0000);
		// a foreign address byte gets no ack
		host.start();
		host.wr_byte(8'h30, ack);
		host.stop();
		chk(16'(ack), 16'h0001);
		$display("test standby and addressing done");
		// continuous mode at 1, 8 and 128 conversions
		foreach (codes[k]) begin
			reg_wr(als_pkg::REG_PARAM, {5'h10, codes[k]});
			fork
				reg_wr(als_pkg::REG_CTRL, 8'h01);
				measure(n);
			join
			chk_span(n, (CONV_CYC << codes[k]) - 2, (CONV_CYC << codes[k]) + 3);
			finish_run(1'b1);
		end
		$display("test continuous mode done");
		// standard mode, 8 conversions, result only at frame end
		reg_wr(als_pkg::REG_PARAM, 8'h03);
		fork
			reg_wr(als_pkg::REG_CTRL, 8'h01);
			measure(n);
		join
		chk_span(n, FRAME_CYC - 2, FRAME_CYC + 3);
		finish_run(1'b0);
		$display("test standard mode done");
		conclude();
	end
endmodule : light_sensor_read_and_conversion_bench
